// *** design/sbdp_subtract_datapath.v ***
`timescale 1ns/1ps
// Function
// [RULE1] Indexed-by-L operand address is index register plus L.
// [RULE2] L is a signed offset from -128 to 127.
// [RULE3] Index-addressed operands use the page of their own index register.
// [RULE4] Pointer-pair operands use the pointer page register.
// [RULE5] Memory minus A writes back to pointer location in 4 cycles.
// [RULE6] Memory minus 8-bit immediate writes back in 5 cycles.
// [RULE7] Pointer memory minus index memory writes pointer location in 5 cycles.
// [RULE8] Destination uses pointer page, source uses its index page, independently.
// [RULE9] Accumulator pair minus chosen pair kept in accumulator pair.
// [RULE10] Accumulator pair minus 16-bit immediate completes in 3 cycles.
// [RULE11] Pointer pair minus chosen pair kept in pointer pair.
// [RULE12] Pointer pair minus 16-bit immediate completes in 3 cycles.
// [RULE13] Indexed-by-L accumulator subtract completes in 4 cycles into A.
// [RULE14] 8-bit ops set NVCZ with D/U; 16-bit ops binary only.
// [RULE15] Decimal gives BCD difference; unpacked works on low digit only.
`include "sbdp_defines.vh"

module sbdp_subtract_datapath #(
  parameter ADDR_W = 24
) (
  input  wire              CLK_I,
  input  wire              RESET_N_I,
  input  wire              PSEL_I,
  input  wire              PENABLE_I,
  input  wire              PWRITE_I,
  input  wire [11:0]       PADDR_I,
  input  wire [31:0]       PWDATA_I,
  output reg  [31:0]       PRDATA_O,
  output reg               PREADY_O,
  output reg               PSLVERR_O,
  output reg  [ADDR_W-1:0] MEM_ADDR_O,
  output reg               MEM_RD_O,
  output reg               MEM_WR_O,
  output reg  [7:0]        MEM_WDATA_O,
  input  wire [7:0]        MEM_RDATA_I,
  output reg               BUSY_O
);

  localparam ST_IDLE  = 4'b0001;
  localparam ST_RD1   = 4'b0010;
  localparam ST_RD2   = 4'b0100;
  localparam ST_WAIT  = 4'b1000;

  reg [3:0]  state_reg;
  reg [3:0]  state_next;
  reg [3:0]  op_reg;
  reg [1:0]  sel_reg;
  reg        paged_reg;
  reg [15:0] ba_reg;
  reg [15:0] hl_reg;
  reg [15:0] ix_reg;
  reg [15:0] iy_reg;
  reg [7:0]  page_for_first_index_reg;
  reg [7:0]  page_for_second_index_reg;
  reg [7:0]  page_for_pointer_access_reg;
  reg [15:0] imm_reg;
  reg [5:0]  flags_reg;
  reg [7:0]  src_reg;
  reg [2:0]  cnt_reg;
  reg        done_reg;

  // Writes land on the edge that completes the transfer, not the one before
  wire wr_acc = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O & ~BUSY_O;
  wire index_select = sel_reg[0];

  // ****************************************************************
  // Operand addresses
  // ****************************************************************
  wire [15:0] idx_base = index_select ? iy_reg : ix_reg;
  wire [7:0]  idx_page = index_select ? page_for_second_index_reg
                                      : page_for_first_index_reg; // [RULE3]
  wire [15:0] l_sext   = {{8{hl_reg[7]}}, hl_reg[7:0]};  // [RULE2]
  wire [15:0] idxl_adr = idx_base + l_sext;              // [RULE1]
  wire [7:0]  pg_idx   = paged_reg ? idx_page : 8'h00;
  wire [7:0]  pg_ptr   = paged_reg ? page_for_pointer_access_reg : 8'h00; // [RULE4]
  wire [ADDR_W-1:0] adr_idxl = {{(ADDR_W-24){1'b0}}, pg_idx, idxl_adr};
  wire [ADDR_W-1:0] adr_idx  = {{(ADDR_W-24){1'b0}}, pg_idx, idx_base};  // [RULE8]
  wire [ADDR_W-1:0] adr_ptr  = {{(ADDR_W-24){1'b0}}, pg_ptr, hl_reg};    // [RULE8]

  // ****************************************************************
  // 8-bit subtract with decimal and unpacked modes
  // ****************************************************************
  reg [7:0] sub_a;
  reg [7:0] sub_b;
  reg [7:0] res8;
  reg [3:0] n_flg;
  reg [8:0] bin;
  reg [4:0] lo;
  reg [4:0] hi;
  reg       lo_brw;

  always @*
  begin
    sub_a  = 8'h00;
    sub_b  = 8'h00;
    case (op_reg)
      `SBDP_OP_A_IDXL: begin sub_a = ba_reg[7:0]; sub_b = MEM_RDATA_I; end
      `SBDP_OP_M_A:    begin sub_a = MEM_RDATA_I; sub_b = ba_reg[7:0]; end  // [RULE5]
      `SBDP_OP_M_IMM:  begin sub_a = MEM_RDATA_I; sub_b = imm_reg[7:0]; end // [RULE6]
      `SBDP_OP_M_M:    begin sub_a = MEM_RDATA_I; sub_b = src_reg; end      // [RULE7]
      default:         begin sub_a = 8'h00; sub_b = 8'h00; end
    endcase
    bin    = {1'b0, sub_a} - {1'b0, sub_b};
    lo     = {1'b0, sub_a[3:0]} - {1'b0, sub_b[3:0]};
    lo_brw = lo[4];
    if (lo_brw)
      lo = lo - 5'h06;
    hi     = {1'b0, sub_a[7:4]} - {1'b0, sub_b[7:4]} - {4'h0, lo_brw};
    if (hi[4])
      hi = hi - 5'h06;
    res8   = bin[7:0];
    // Flags as N V C Z, filled below per mode
    n_flg  = {bin[7], (sub_a[7] ^ sub_b[7]) & (sub_a[7] ^ bin[7]), bin[8], bin[7:0] == 8'h00};
    if (flags_reg[`SBDP_FLG_D] && flags_reg[`SBDP_FLG_U])
    begin
      // Unpacked keeps a single digit; upper nibble of result is zero
      res8  = {4'h0, lo[3:0]};                           // [RULE15]
      n_flg = {1'b0, 1'b0, lo_brw, lo[3:0] == 4'h0};
    end
    else if (flags_reg[`SBDP_FLG_D])
    begin
      res8  = {hi[3:0], lo[3:0]};                        // [RULE15]
      n_flg = {1'b0, 1'b0, hi[4], {hi[3:0], lo[3:0]} == 8'h00};
    end
  end

  // ****************************************************************
  // 16-bit binary subtract
  // ****************************************************************
  reg [15:0] pair_operand;
  reg [15:0] min16;
  reg [16:0] bin16;

  always @*
  begin
    case (sel_reg)
      2'h0:    pair_operand = ba_reg;
      2'h1:    pair_operand = hl_reg;
      2'h2:    pair_operand = ix_reg;
      default: pair_operand = iy_reg;
    endcase
    min16 = (op_reg == `SBDP_OP_HL_RP || op_reg == `SBDP_OP_HL_IMM) ? hl_reg : ba_reg;
    if (op_reg == `SBDP_OP_BA_IMM || op_reg == `SBDP_OP_HL_IMM)
      bin16 = {1'b0, min16} - {1'b0, imm_reg};           // [RULE10] [RULE12]
    else
      bin16 = {1'b0, min16} - {1'b0, pair_operand};      // [RULE9] [RULE11]
  end

  wire [3:0] flg16 = {bin16[15],
                      (min16[15] ^ bin16[15]) &
                      (min16[15] ^ ((op_reg[0]) ? imm_reg[15] : pair_operand[15])),
                      bin16[16], bin16[15:0] == 16'h0000}; // [RULE14]

  wire is16 = op_reg[2];
  wire [2:0] len = (op_reg == `SBDP_OP_A_IDXL) ? 3'd`SBDP_CYC_A_IDXL :
                   (op_reg == `SBDP_OP_M_A)    ? 3'd`SBDP_CYC_M_A :
                   (op_reg == `SBDP_OP_M_IMM)  ? 3'd`SBDP_CYC_M_IMM :
                   (op_reg == `SBDP_OP_M_M)    ? 3'd`SBDP_CYC_M_M :
                   op_reg[0]                   ? 3'd`SBDP_CYC_IMM16 : 3'd`SBDP_CYC_RP;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (wr_acc && PADDR_I == `SBDP_OFF_CTRL && PWDATA_I[`SBDP_CTRL_GO])
          state_next = ST_RD1;
      ST_RD1:
        if (is16)
          state_next = ST_WAIT;
        else
          state_next = (op_reg == `SBDP_OP_M_M) ? ST_RD2 : ST_WAIT;
      ST_RD2:
        state_next = ST_WAIT;
      ST_WAIT:
        if (cnt_reg == len)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      state_reg   <= ST_IDLE;
      op_reg      <= 4'h0;
      sel_reg     <= 2'h0;
      paged_reg   <= 1'b0;
      ba_reg      <= 16'h0000;
      hl_reg      <= 16'h0000;
      ix_reg      <= 16'h0000;
      iy_reg      <= 16'h0000;
      page_for_first_index_reg    <= 8'h00;
      page_for_second_index_reg   <= 8'h00;
      page_for_pointer_access_reg <= 8'h00;
      imm_reg     <= 16'h0000;
      flags_reg   <= 6'h00;
      src_reg     <= 8'h00;
      cnt_reg     <= 3'h0;
      done_reg    <= 1'b0;
      MEM_ADDR_O  <= {ADDR_W{1'b0}};
      MEM_RD_O    <= 1'b0;
      MEM_WR_O    <= 1'b0;
      MEM_WDATA_O <= 8'h00;
      BUSY_O      <= 1'b0;
      PRDATA_O    <= 32'h0000_0000;
      PREADY_O    <= 1'b0;
      PSLVERR_O   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      MEM_RD_O  <= 1'b0;
      MEM_WR_O  <= 1'b0;
      // APB: one wait state, answer on second access cycle
      PREADY_O  <= PSEL_I & PENABLE_I & ~PREADY_O;
      PSLVERR_O <= 1'b0;
      if (PSEL_I && PENABLE_I && !PREADY_O)
      begin
        PSLVERR_O <= (PADDR_I > `SBDP_OFF_FLAGS) || (PADDR_I[1:0] != 2'b00)
                     || (PWRITE_I && BUSY_O);
        case (PADDR_I)
          `SBDP_OFF_CTRL:   PRDATA_O <= {19'h0, paged_reg, 2'h0, sel_reg, op_reg, 4'h0};
          `SBDP_OFF_STATUS: PRDATA_O <= {30'h0, done_reg, BUSY_O};
          `SBDP_OFF_BA:     PRDATA_O <= {16'h0, ba_reg};
          `SBDP_OFF_HL:     PRDATA_O <= {16'h0, hl_reg};
          `SBDP_OFF_IX:     PRDATA_O <= {16'h0, ix_reg};
          `SBDP_OFF_IY:     PRDATA_O <= {16'h0, iy_reg};
          `SBDP_OFF_PAGES:  PRDATA_O <= {8'h0, page_for_pointer_access_reg,
                                         page_for_second_index_reg, page_for_first_index_reg};
          `SBDP_OFF_IMM:    PRDATA_O <= {16'h0, imm_reg};
          `SBDP_OFF_FLAGS:  PRDATA_O <= {26'h0, flags_reg};
          default:          PRDATA_O <= `SBDP_RST_WORD;
        endcase
      end
      if (wr_acc)
          case (PADDR_I)
            `SBDP_OFF_CTRL:
            begin
              op_reg    <= PWDATA_I[`SBDP_CTRL_OP_MSB:`SBDP_CTRL_OP_LSB];
              sel_reg   <= PWDATA_I[`SBDP_CTRL_SEL_MSB:`SBDP_CTRL_SEL_LSB];
              paged_reg <= PWDATA_I[`SBDP_CTRL_PAGED];
              if (PWDATA_I[`SBDP_CTRL_GO])
              begin
                BUSY_O   <= 1'b1;
                done_reg <= 1'b0;
                cnt_reg  <= 3'h1;
              end
            end
            `SBDP_OFF_BA:    ba_reg  <= PWDATA_I[15:0];
            `SBDP_OFF_HL:    hl_reg  <= PWDATA_I[15:0];
            `SBDP_OFF_IX:    ix_reg  <= PWDATA_I[15:0];
            `SBDP_OFF_IY:    iy_reg  <= PWDATA_I[15:0];
            `SBDP_OFF_PAGES:
            begin
              page_for_first_index_reg    <= PWDATA_I[7:0];
              page_for_second_index_reg   <= PWDATA_I[15:8];
              page_for_pointer_access_reg <= PWDATA_I[23:16];
            end
            `SBDP_OFF_IMM:   imm_reg   <= PWDATA_I[15:0];
            `SBDP_OFF_FLAGS: flags_reg <= PWDATA_I[5:0];
            default:         imm_reg   <= imm_reg;
          endcase
      if (state_reg != ST_IDLE)
        cnt_reg <= cnt_reg + 3'h1;
      case (state_reg)
        ST_RD1:
          if (!is16)
          begin
            MEM_RD_O <= 1'b1;
            // Copy source first; memory answers in the same cycle that the strobe is high
            if (op_reg == `SBDP_OP_A_IDXL)
              MEM_ADDR_O <= adr_idxl;                    // [RULE1] [RULE3]
            else if (op_reg == `SBDP_OP_M_M)
              MEM_ADDR_O <= adr_idx;                     // [RULE8]
            else
              MEM_ADDR_O <= adr_ptr;                     // [RULE4]
          end
        ST_RD2:
        begin
          src_reg    <= MEM_RDATA_I;
          MEM_RD_O   <= 1'b1;
          MEM_ADDR_O <= adr_ptr;                         // [RULE8]
        end
        ST_WAIT:
        begin
          if (cnt_reg == len)
          begin
            BUSY_O   <= 1'b0;
            done_reg <= 1'b1;
            if (is16)
            begin
              flags_reg[3:0] <= flg16;                   // [RULE14]
              if (op_reg[1])
                hl_reg <= bin16[15:0];                   // [RULE11] [RULE12]
              else
                ba_reg <= bin16[15:0];                   // [RULE9] [RULE10]
            end
          end
          // Operand is valid only while the read strobe stands
          if (!is16 && MEM_RD_O)
          begin
            flags_reg[3:0] <= n_flg;                     // [RULE14]
            if (op_reg == `SBDP_OP_A_IDXL)
              ba_reg[7:0] <= res8;                       // [RULE13]
            else
            begin
              MEM_WR_O    <= 1'b1;                       // [RULE5] [RULE6] [RULE7]
              MEM_WDATA_O <= res8;
            end
          end
        end
        default: cnt_reg <= cnt_reg;
      endcase
    end
  end

endmodule

// *** design/sbdp_defines.vh ***
`ifndef SBDP_DEFINES_VH
`define SBDP_DEFINES_VH

// APB register byte offsets
`define SBDP_OFF_CTRL     12'h000
`define SBDP_OFF_STATUS   12'h004
`define SBDP_OFF_BA       12'h008
`define SBDP_OFF_HL       12'h00C
`define SBDP_OFF_IX       12'h010
`define SBDP_OFF_IY       12'h014
`define SBDP_OFF_PAGES    12'h018
`define SBDP_OFF_IMM      12'h01C
`define SBDP_OFF_FLAGS    12'h020

// Control word fields
`define SBDP_CTRL_GO      0
`define SBDP_CTRL_OP_LSB  4
`define SBDP_CTRL_OP_MSB  7
`define SBDP_CTRL_SEL_LSB 8
`define SBDP_CTRL_SEL_MSB 9
`define SBDP_CTRL_PAGED   12

// Flag word fields
`define SBDP_FLG_Z        0
`define SBDP_FLG_C        1
`define SBDP_FLG_V        2
`define SBDP_FLG_N        3
`define SBDP_FLG_D        4
`define SBDP_FLG_U        5

// Operation codes
`define SBDP_OP_A_IDXL    4'h0
`define SBDP_OP_M_A       4'h1
`define SBDP_OP_M_IMM     4'h2
`define SBDP_OP_M_M       4'h3
`define SBDP_OP_BA_RP     4'h4
`define SBDP_OP_BA_IMM    4'h5
`define SBDP_OP_HL_RP     4'h6
`define SBDP_OP_HL_IMM    4'h7

// Instruction lengths in core cycles
`define SBDP_CYC_A_IDXL   4
`define SBDP_CYC_M_A      4
`define SBDP_CYC_M_IMM    5
`define SBDP_CYC_M_M      5
`define SBDP_CYC_RP       4
`define SBDP_CYC_IMM16    3

// Reset values
`define SBDP_RST_WORD     32'h0000_0000

`endif

// *** sim/sbdp_subtract_checker.sv ***
`timescale 1ns/1ps
`include "sbdp_defines.vh"
module sbdp_subtract_checker (
  input wire logic        CLK_I,
  input wire logic        RESET_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        MEM_RD_O,
  input wire logic        MEM_WR_O,
  input wire logic        BUSY_O
);
  // ***
  // Bus and operation checks
  // ***
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  sequence s_access;
    PSEL_I && PENABLE_I;
  endsequence
  sequence s_go;
    s_access ##0 (PWRITE_I && PADDR_I == `SBDP_OFF_CTRL && PWDATA_I[`SBDP_CTRL_GO]
                  && PREADY_O && !PSLVERR_O);
  endsequence
  a_mem_rd_busy:
    assert property (MEM_RD_O |-> BUSY_O) else $error("memory read while idle");
  a_mem_wr_busy:
    assert property (MEM_WR_O |-> BUSY_O) else $error("memory write while idle");
  a_rd_wr_excl:
    assert property (!(MEM_RD_O && MEM_WR_O)) else $error("memory read and write together");
  a_wr_after_rd:
    assert property (MEM_WR_O |-> $past(MEM_RD_O)) else $error("write without prior read");
  a_ready_access:
    assert property (PREADY_O |-> s_access) else $error("ready outside access phase");
  a_err_ready:
    assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
  a_ready_prompt:
    assert property ($rose(PENABLE_I) && PSEL_I |-> ##[0:2] PREADY_O) else $error("ready late");
  a_go_busy:
    assert property (s_go |=> ##[0:2] BUSY_O) else $error("start did not raise busy");
  a_busy_ends:
    assert property ($rose(BUSY_O) |-> ##[1:40] !BUSY_O) else $error("operation too long");
endmodule

bind sbdp_subtract_datapath sbdp_subtract_checker sbdp_subtract_checker_i (
  .CLK_I(CLK_I),
  .RESET_N_I(RESET_N_I),
  .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I),
  .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O),
  .MEM_RD_O(MEM_RD_O),
  .MEM_WR_O(MEM_WR_O),
  .BUSY_O(BUSY_O)
);

// *** sim/sbdp_mem_model.sv ***
`timescale 1ns/1ps
module sbdp_mem_model (
  input  wire logic        clk_i,
  input  wire logic [23:0] addr_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg = 8'h5A;
  // Idle bus shows inverse of last byte so stale data never passes
  assign rdata_o = rd_i ? mem[addr_i[15:0]] : ~last_reg;
  always @(posedge clk_i)
  begin
    if (rd_i)
      last_reg <= mem[addr_i[15:0]];
    if (wr_i)
      mem[addr_i[15:0]] <= wdata_i;
  end
endmodule

// *** sim/tb_sbdp_subtract_datapath.sv ***
`timescale 1ns/1ps
`include "sbdp_defines.vh"
module tb_sbdp_subtract_datapath;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [23:0] maddr;
  logic        mrd;
  logic        mwr;
  logic [7:0]  mwdata;
  logic [7:0]  mrdata;
  logic        busy;
  logic [31:0] rdata;
  int          num_errors = 0;
  int          n_compared = 0;

  always #4 clk = ~clk;

  sbdp_subtract_datapath sbdp_subtract_datapath_i (
    .CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .MEM_ADDR_O(maddr), .MEM_RD_O(mrd),
    .MEM_WR_O(mwr), .MEM_WDATA_O(mwdata), .MEM_RDATA_I(mrdata), .BUSY_O(busy)
  );
  sbdp_mem_model sbdp_mem_model_i (
    .clk_i(clk), .addr_i(maddr), .rd_i(mrd), .wr_i(mwr), .wdata_i(mwdata), .rdata_o(mrdata)
  );

  // ***
  // Helpers
  // ***
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    check("apb ready", {31'h0, pready}, 32'h1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task go(input logic [3:0] op, input logic [1:0] sel);
    int n;
    n = 0;
    apb(1'b1, `SBDP_OFF_CTRL, {22'h0, sel, op, 4'h1});
    @(posedge clk);
    while (busy !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    check("busy done", {31'h0, busy}, 32'h0);
  endtask

  task flg(input logic [3:0] f);
    apb(1'b0, `SBDP_OFF_FLAGS, 32'h0);
    check("flags", {28'h0, rdata[3:0]}, {28'h0, f});
  endtask

  task mem_is(input logic [15:0] a, input logic [7:0] v);
    check("memory byte", {24'h0, sbdp_mem_model_i.mem[a]}, {24'h0, v});
  endtask

  // ***
  // Scenarios
  // ***
  task t_reset;
    apb(1'b0, `SBDP_OFF_BA, 32'h0);
    check("BA reset", rdata, `SBDP_RST_WORD);
    apb(1'b0, `SBDP_OFF_FLAGS, 32'h0);
    check("flags reset", rdata, `SBDP_RST_WORD);
    apb(1'b0, 12'hFFC, 32'h0);
  endtask

  task t_idx;
    sbdp_mem_model_i.mem[16'h0FFE] = 8'h42;
    apb(1'b1, `SBDP_OFF_BA, 32'hA8);
    apb(1'b1, `SBDP_OFF_HL, 32'hFE);
    apb(1'b1, `SBDP_OFF_IX, 32'h1000);
    go(`SBDP_OP_A_IDXL, 2'h0);
    apb(1'b0, `SBDP_OFF_BA, 32'h0);
    check("indexed result", rdata, 32'h66);
    flg(4'h4);
  endtask

  task t_mem_a;
    sbdp_mem_model_i.mem[16'h2000] = 8'h36;
    apb(1'b1, `SBDP_OFF_HL, 32'h2000);
    apb(1'b1, `SBDP_OFF_BA, 32'h5A);
    go(`SBDP_OP_M_A, 2'h0);
    mem_is(16'h2000, 8'hDC);
    flg(4'hA);
  endtask

  task t_dec;
    for (int u = 0; u < 2; u++)
    begin
      sbdp_mem_model_i.mem[16'h2000] = 8'h88;
      apb(1'b1, `SBDP_OFF_FLAGS, 32'h10 | (u << 5));
      apb(1'b1, `SBDP_OFF_IMM, 32'h39);
      go(`SBDP_OP_M_IMM, 2'h0);
      mem_is(16'h2000, u ? 8'h09 : 8'h49);
      flg(u ? 4'h2 : 4'h0);
    end
  endtask

  task t_mm;
    sbdp_mem_model_i.mem[16'h2000] = 8'hA8;
    sbdp_mem_model_i.mem[16'h3000] = 8'h42;
    apb(1'b1, `SBDP_OFF_FLAGS, 32'h0);
    apb(1'b1, `SBDP_OFF_IY, 32'h3000);
    go(`SBDP_OP_M_M, 2'h1);
    mem_is(16'h2000, 8'h66);
    flg(4'h4);
  endtask

  task t_wide;
    logic [3:0]  op [5] = '{`SBDP_OP_BA_RP, `SBDP_OP_BA_RP, `SBDP_OP_HL_RP,
                            `SBDP_OP_BA_IMM, `SBDP_OP_HL_IMM};
    logic [1:0]  sl [5] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h0};
    logic [11:0] ds [5] = '{12'h008, 12'h008, 12'h00C, 12'h008, 12'h00C};
    logic [11:0] sr [5] = '{12'h00C, 12'h008, 12'h010, 12'h01C, 12'h01C};
    logic [15:0] a  [5] = '{16'h63C2, 16'h1234, 16'hC261, 16'h205C, 16'h63C2};
    logic [15:0] b  [5] = '{16'h2125, 16'h1234, 16'h5A32, 16'h7120, 16'h2125};
    logic [15:0] r  [5] = '{16'h429D, 16'h0000, 16'h682F, 16'hAF3C, 16'h429D};
    logic [3:0]  f  [5] = '{4'h0, 4'h1, 4'h4, 4'hA, 4'h0};
    // Decimal mode left on: wide results must stay binary
    apb(1'b1, `SBDP_OFF_FLAGS, 32'h10);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, ds[i], {16'h0, a[i]});
      apb(1'b1, sr[i], {16'h0, b[i]});
      go(op[i], sl[i]);
      apb(1'b0, ds[i], 32'h0);
      check("wide result", rdata, {16'h0, r[i]});
      flg(f[i]);
    end
  endtask

  task stop_test;
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_idx;
    t_mem_a;
    t_dec;
    t_mm;
    t_wide;
    stop_test;
  end

  initial
  begin
    #200000;
    num_errors++;
    stop_test;
  end
endmodule
